// file: inc/iobm_pkg.sv
// constants for the control-bus and general-pin multiplexer
// assumes one clock, registers written over a plain internal byte port
// Function
// R1: all 28 control-bus lines carry either the memory set or the converter/FIFO set, per config.
// R2: memory role drives lines 0-15 as address, 16 as write strobe low, 17 as read strobe low.
// R3: memory role drives lines 18-21 as four active-low partition chip selects.
// R4: memory role drives 22 test, 23 tx ready, 24 rx ready and samples 25 bus request, 26, 27.
// R5: converter role drives 0-7 as converter address, 8 chip select low, 9 read/convert low.
// R6: converter role drives 10 as DAC write strobe low and 11-13 as DAC address.
// R7: in converter role lines 22 and 23 come from outside as ready and trigger, sampled only.
// R8: FIFO role drives 14 tx packet-end ack, 15 rx parity, 16-17 rx packet-end marks.
// R9: FIFO role lines 18-21 are read, write, empty, full, direction set by data flow.
// R10: in FIFO role lines 24-25 tx packet-end marks, 26 rx ack and 27 tx parity come from outside.
// R11: general pins follow the general-pin data register unless their pair's select bit is set.
// R12: first uart control bit 7 maps pin 0 to its rts output and pin 1 to its cts input.
// R13: interface config bit 6 maps pins 2 and 3 to external interrupt request inputs 0 and 1.
// R14: interface config bit 7 maps pin 4 to second uart transmit and pin 5 to its receive.
// R15: second uart control bit 7 maps pin 6 to its rts output and pin 7 to its cts input.
// R16: select bits choose the alternate when one, reset to zero; the role is a stored field.
package iobm_pkg;
    localparam logic [7:0] INTERFACE_CONFIG_OFS = 8'h01;
    localparam logic [7:0] FIRST_UART_CONTROL_OFS = 8'h59;
    localparam logic [7:0] GENERAL_PIN_DATA_OFS = 8'h63;
    localparam logic [7:0] GENERAL_PIN_DIR_OFS = 8'h64;
    localparam logic [7:0] SECOND_UART_CONTROL_OFS = 8'h72;
    localparam logic [7:0] REG_RESET = 8'h00;
    // interface_config and uart control fields
    localparam int CFG_ROLE_BIT = 0;
    localparam int CFG_FIFO_TX_BIT = 1;
    localparam int CFG_IRQ_SEL_BIT = 6;
    localparam int CFG_UART2_SEL_BIT = 7;
    localparam int UART_RTS_SEL_BIT = 7;
    // control-bus pin state after reset: memory role, strobes and selects high
    localparam logic [27:0] BUS_OUT_RESET = 28'h03F0000;
    localparam logic [27:0] BUS_OE_MEMORY = 28'h1FFFFFF;
    localparam logic [27:0] BUS_OE_CONVERTER = 28'h003FFFF;
    // pin synchronisers reset to the pull-up level of an idle pin
    localparam logic [27:0] BUS_IN_IDLE = 28'hFFFFFFF;
    localparam logic [7:0] GP_IN_IDLE = 8'hFF;
    localparam logic [3:0] FIFO_OE_TX = 4'h1;
    localparam logic [3:0] FIFO_OE_RX = 4'h2;
endpackage

// file: logic/iobm_pin_mux.sv
// control-bus role multiplexer and general-pin alternate-function mux
// assumes pin inputs are asynchronous; user-side signals share ref_clk_i
`timescale 1ns/1ps
module iobm_pin_mux (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic reg_wr_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    output logic [7:0] reg_rdata_o,
    input wire logic [27:0] control_bus_line_i,
    output logic [27:0] control_bus_line_o,
    output logic [27:0] control_bus_line_oe_o,
    input wire logic [7:0] gp_pin_i,
    output logic [7:0] gp_pin_o,
    output logic [7:0] gp_pin_oe_o,
    input wire logic [15:0] mem_addr_i,
    input wire logic mem_write_n_i,
    input wire logic mem_read_n_i,
    input wire logic [3:0] memory_chip_select_n_i,
    input wire logic mem_test_i,
    input wire logic memory_transmit_ready_i,
    input wire logic memory_receive_ready_i,
    output logic mem_bus_request_n_o,
    output logic memory_start_transmit_o,
    output logic memory_start_receive_o,
    input wire logic [7:0] conv_addr_i,
    input wire logic conv_cs_n_i,
    input wire logic conv_read_convert_n_i,
    input wire logic dac_write_n_i,
    input wire logic [2:0] dac_address_bit_i,
    output logic conv_ready_o,
    output logic converter_trigger_in_o,
    input wire logic tx_end_packet_ack_i,
    input wire logic rx_parity_out_i,
    input wire logic [1:0] rx_end_packet_mark_i,
    input wire logic fifo_read_strobe_n_i,
    input wire logic queue_write_strobe_n_i,
    output logic fifo_empty_n_o,
    output logic fifo_full_n_o,
    output logic [1:0] tx_end_packet_mark_o,
    output logic rx_end_packet_ack_o,
    output logic tx_parity_in_o,
    input wire logic first_serial_rts_n_i,
    output logic first_serial_cts_n_o,
    output logic external_irq0_n_o,
    output logic external_irq1_n_o,
    input wire logic second_serial_tx_i,
    output logic second_serial_rx_o,
    input wire logic second_serial_rts_n_i,
    output logic second_serial_cts_n_o
);
    typedef struct packed {
        logic [7:0] cfg;
        logic [7:0] uart1;
        logic [7:0] uart2;
        logic [7:0] gdata;
        logic [7:0] gdir;
        logic [7:0] rdata;
        logic [27:0] bus_o;
        logic [27:0] bus_oe;
        logic [7:0] gp_o;
        logic [7:0] gp_oe;
        logic [27:0] bus_s1;
        logic [27:0] bus_s2;
        logic [7:0] gp_s1;
        logic [7:0] gp_s2;
        logic breq_n;
        logic st_tx;
        logic st_rx;
        logic c_rdy;
        logic c_trig;
        logic f_empty_n;
        logic f_full_n;
        logic [1:0] tx_eop;
        logic rx_ack;
        logic tx_par;
        logic cts1_n;
        logic irq0_n;
        logic irq1_n;
        logic rx2;
        logic cts2_n;
    } iobm_state_t;

    iobm_state_t st_ff;
    iobm_state_t nxt_st;

    // unmapped offsets read as zero
    function automatic logic [7:0] iobm_read(input logic [7:0] a, input iobm_state_t s);
        case (a)
            iobm_pkg::INTERFACE_CONFIG_OFS: iobm_read = s.cfg;
            iobm_pkg::FIRST_UART_CONTROL_OFS: iobm_read = s.uart1;
            iobm_pkg::GENERAL_PIN_DATA_OFS: iobm_read = s.gp_s2;
            iobm_pkg::GENERAL_PIN_DIR_OFS: iobm_read = s.gdir;
            iobm_pkg::SECOND_UART_CONTROL_OFS: iobm_read = s.uart2;
            default: iobm_read = 8'h00;
        endcase
    endfunction

    logic conv_role;
    logic fifo_tx;
    logic sel01;
    logic sel23;
    logic sel45;
    logic sel67;
    assign conv_role = st_ff.cfg[iobm_pkg::CFG_ROLE_BIT]; // R16
    assign fifo_tx = st_ff.cfg[iobm_pkg::CFG_FIFO_TX_BIT];
    assign sel01 = st_ff.uart1[iobm_pkg::UART_RTS_SEL_BIT];
    assign sel23 = st_ff.cfg[iobm_pkg::CFG_IRQ_SEL_BIT];
    assign sel45 = st_ff.cfg[iobm_pkg::CFG_UART2_SEL_BIT];
    assign sel67 = st_ff.uart2[iobm_pkg::UART_RTS_SEL_BIT];

    always_comb begin
        nxt_st = st_ff;
        if (reg_wr_i) begin
            case (reg_addr_i)
                iobm_pkg::INTERFACE_CONFIG_OFS: nxt_st.cfg = reg_wdata_i;
                iobm_pkg::FIRST_UART_CONTROL_OFS: nxt_st.uart1 = reg_wdata_i;
                iobm_pkg::GENERAL_PIN_DATA_OFS: nxt_st.gdata = reg_wdata_i;
                iobm_pkg::GENERAL_PIN_DIR_OFS: nxt_st.gdir = reg_wdata_i;
                iobm_pkg::SECOND_UART_CONTROL_OFS: nxt_st.uart2 = reg_wdata_i;
                default: nxt_st.cfg = st_ff.cfg;
            endcase
        end
        nxt_st.rdata = iobm_read(reg_addr_i, st_ff);
        nxt_st.bus_s1 = control_bus_line_i;
        nxt_st.bus_s2 = st_ff.bus_s1;
        nxt_st.gp_s1 = gp_pin_i;
        nxt_st.gp_s2 = st_ff.gp_s1;
        // sampled inputs read as inactive outside their role
        nxt_st.breq_n = 1'b1;
        nxt_st.st_tx = 1'b0;
        nxt_st.st_rx = 1'b0;
        nxt_st.c_rdy = 1'b0;
        nxt_st.c_trig = 1'b0;
        nxt_st.f_empty_n = 1'b1;
        nxt_st.f_full_n = 1'b1;
        nxt_st.tx_eop = 2'h0;
        nxt_st.rx_ack = 1'b0;
        nxt_st.tx_par = 1'b0;
        if (!conv_role) begin
            nxt_st.bus_o = {3'h0, memory_receive_ready_i, memory_transmit_ready_i, // R4
                mem_test_i, memory_chip_select_n_i, // R3
                mem_read_n_i, mem_write_n_i, mem_addr_i}; // R2
            nxt_st.bus_oe = iobm_pkg::BUS_OE_MEMORY; // R1
            nxt_st.breq_n = st_ff.bus_s2[25]; // R4
            nxt_st.st_tx = st_ff.bus_s2[26];
            nxt_st.st_rx = st_ff.bus_s2[27];
        end else begin
            nxt_st.bus_o = {8'h00, queue_write_strobe_n_i, fifo_read_strobe_n_i, // R9
                rx_end_packet_mark_i, rx_parity_out_i, tx_end_packet_ack_i, // R8
                dac_address_bit_i, dac_write_n_i, // R6
                conv_read_convert_n_i, conv_cs_n_i, conv_addr_i}; // R5
            // lines 18-21: device drives the strobe of its own flow direction only
            nxt_st.bus_oe = iobm_pkg::BUS_OE_CONVERTER; // R1
            nxt_st.bus_oe[21:18] = fifo_tx ? iobm_pkg::FIFO_OE_TX : iobm_pkg::FIFO_OE_RX; // R9
            nxt_st.c_rdy = st_ff.bus_s2[22]; // R7
            nxt_st.c_trig = st_ff.bus_s2[23];
            nxt_st.f_empty_n = fifo_tx ? st_ff.bus_s2[20] : 1'b1; // R9
            nxt_st.f_full_n = fifo_tx ? 1'b1 : st_ff.bus_s2[21];
            nxt_st.tx_eop = st_ff.bus_s2[25:24]; // R10
            nxt_st.rx_ack = st_ff.bus_s2[26];
            nxt_st.tx_par = st_ff.bus_s2[27];
        end
        nxt_st.gp_o = st_ff.gdata; // R11
        nxt_st.gp_oe = st_ff.gdir;
        if (sel01) begin
            nxt_st.gp_o[0] = first_serial_rts_n_i; // R12
            nxt_st.gp_oe[1:0] = 2'h1;
        end
        if (sel23) begin
            nxt_st.gp_oe[3:2] = 2'h0; // R13
        end
        if (sel45) begin
            nxt_st.gp_o[4] = second_serial_tx_i; // R14
            nxt_st.gp_oe[5:4] = 2'h1;
        end
        if (sel67) begin
            nxt_st.gp_o[6] = second_serial_rts_n_i; // R15
            nxt_st.gp_oe[7:6] = 2'h1;
        end
        nxt_st.cts1_n = sel01 ? st_ff.gp_s2[1] : 1'b1; // R12
        nxt_st.irq0_n = sel23 ? st_ff.gp_s2[2] : 1'b1; // R13
        nxt_st.irq1_n = sel23 ? st_ff.gp_s2[3] : 1'b1;
        nxt_st.rx2 = sel45 ? st_ff.gp_s2[5] : 1'b1; // R14
        nxt_st.cts2_n = sel67 ? st_ff.gp_s2[7] : 1'b1; // R15
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            st_ff <= '0;
            st_ff.bus_o <= iobm_pkg::BUS_OUT_RESET;
            st_ff.bus_oe <= iobm_pkg::BUS_OE_MEMORY;
            st_ff.breq_n <= 1'b1;
            st_ff.f_empty_n <= 1'b1;
            st_ff.f_full_n <= 1'b1;
            st_ff.cts1_n <= 1'b1;
            st_ff.irq0_n <= 1'b1;
            st_ff.irq1_n <= 1'b1;
            st_ff.rx2 <= 1'b1;
            st_ff.cts2_n <= 1'b1;
            // zero here would fake a bus request for two cycles after reset
            st_ff.bus_s1 <= iobm_pkg::BUS_IN_IDLE;
            st_ff.bus_s2 <= iobm_pkg::BUS_IN_IDLE;
            st_ff.gp_s1 <= iobm_pkg::GP_IN_IDLE;
            st_ff.gp_s2 <= iobm_pkg::GP_IN_IDLE;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign reg_rdata_o = st_ff.rdata;
    assign control_bus_line_o = st_ff.bus_o;
    assign control_bus_line_oe_o = st_ff.bus_oe;
    assign gp_pin_o = st_ff.gp_o;
    assign gp_pin_oe_o = st_ff.gp_oe;
    assign mem_bus_request_n_o = st_ff.breq_n;
    assign memory_start_transmit_o = st_ff.st_tx;
    assign memory_start_receive_o = st_ff.st_rx;
    assign conv_ready_o = st_ff.c_rdy;
    assign converter_trigger_in_o = st_ff.c_trig;
    assign fifo_empty_n_o = st_ff.f_empty_n;
    assign fifo_full_n_o = st_ff.f_full_n;
    assign tx_end_packet_mark_o = st_ff.tx_eop;
    assign rx_end_packet_ack_o = st_ff.rx_ack;
    assign tx_parity_in_o = st_ff.tx_par;
    assign first_serial_cts_n_o = st_ff.cts1_n;
    assign external_irq0_n_o = st_ff.irq0_n;
    assign external_irq1_n_o = st_ff.irq1_n;
    assign second_serial_rx_o = st_ff.rx2;
    assign second_serial_cts_n_o = st_ff.cts2_n;

    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);

    property p_r1;
        !conv_role |=> control_bus_line_oe_o == 28'h1FFFFFF;
    endproperty
    a_r1: assert property (p_r1) else $error("memory role pin enables wrong"); // R1
    property p_r2;
        !conv_role |=> control_bus_line_o[17:0] == $past({mem_read_n_i, mem_write_n_i, mem_addr_i});
    endproperty
    a_r2: assert property (p_r2) else $error("memory address or strobes wrong"); // R2
    property p_r3;
        !conv_role |=> control_bus_line_o[21:18] == $past(memory_chip_select_n_i);
    endproperty
    a_r3: assert property (p_r3) else $error("memory chip selects wrong"); // R3
    property p_r4;
        !conv_role |=> mem_bus_request_n_o == $past(control_bus_line_i[25], 3);
    endproperty
    a_r4: assert property (p_r4) else $error("bus request sampling wrong"); // R4
    property p_r5;
        conv_role |=> control_bus_line_o[9:0] == $past({conv_read_convert_n_i, conv_cs_n_i, conv_addr_i});
    endproperty
    a_r5: assert property (p_r5) else $error("converter outputs wrong"); // R5
    property p_r6;
        conv_role |=> control_bus_line_o[13:10] == $past({dac_address_bit_i, dac_write_n_i});
    endproperty
    a_r6: assert property (p_r6) else $error("dac outputs wrong"); // R6
    property p_r8;
        conv_role |=> control_bus_line_o[17:14] == $past({rx_end_packet_mark_i, rx_parity_out_i,
            tx_end_packet_ack_i}) && control_bus_line_oe_o[27:22] == 6'h00
            && control_bus_line_oe_o[17:0] == 18'h3FFFF;
    endproperty
    a_r8: assert property (p_r8) else $error("fifo outputs wrong"); // R8
    property p_r7;
        conv_role |=> conv_ready_o == $past(control_bus_line_i[22], 3);
    endproperty
    a_r7: assert property (p_r7) else $error("converter ready sampling wrong"); // R7
    property p_r10;
        conv_role |=> tx_end_packet_mark_o == $past(control_bus_line_i[25:24], 3);
    endproperty
    a_r10: assert property (p_r10) else $error("packet end mark sampling wrong"); // R10
    property p_r9;
        conv_role && fifo_tx |=> control_bus_line_oe_o[21:18] == 4'h1
            && fifo_empty_n_o == $past(control_bus_line_i[20], 3);
    endproperty
    a_r9: assert property (p_r9) else $error("fifo transmit direction wrong"); // R9
    property p_r11;
        !sel45 |=> gp_pin_o[4] == $past(st_ff.gdata[4]) && gp_pin_oe_o[5] == $past(st_ff.gdir[5]);
    endproperty
    a_r11: assert property (p_r11) else $error("general pin not from register"); // R11
    property p_r12;
        sel01 |=> gp_pin_o[0] == $past(first_serial_rts_n_i) && gp_pin_oe_o[1:0] == 2'h1;
    endproperty
    a_r12: assert property (p_r12) else $error("first uart pin pair wrong"); // R12
    property p_r13;
        sel23 |=> gp_pin_oe_o[3:2] == 2'h0 && external_irq0_n_o == $past(gp_pin_i[2], 3);
    endproperty
    a_r13: assert property (p_r13) else $error("interrupt pin pair wrong"); // R13
    property p_r14;
        sel45 |=> gp_pin_o[4] == $past(second_serial_tx_i) && second_serial_rx_o == $past(gp_pin_i[5], 3);
    endproperty
    a_r14: assert property (p_r14) else $error("second uart data pins wrong"); // R14
    property p_r15;
        sel67 |=> gp_pin_o[6] == $past(second_serial_rts_n_i) && second_serial_cts_n_o == $past(gp_pin_i[7], 3);
    endproperty
    a_r15: assert property (p_r15) else $error("second uart modem pins wrong"); // R15
    property p_r16;
        reg_wr_i && reg_addr_i == iobm_pkg::SECOND_UART_CONTROL_OFS |=> sel67 == $past(reg_wdata_i[7]);
    endproperty
    a_r16: assert property (p_r16) else $error("second uart select not stored"); // R16
endmodule

// file: testbench/iobm_far_side.sv
// far-side model: memory, converter, fifo and serial peripherals on the pins
// assumes the device enables mark the lines it drives; undriven pins pull up
`timescale 1ns/1ps
module iobm_far_side (
    input wire logic [27:0] bus_o_i,
    input wire logic [27:0] bus_oe_i,
    input wire logic [27:0] ext_bus_i,
    input wire logic [7:0] gp_o_i,
    input wire logic [7:0] gp_oe_i,
    input wire logic [7:0] ext_gp_i,
    input wire logic [7:0] ext_gp_en_i,
    output logic [27:0] bus_i_o,
    output logic [7:0] gp_i_o
);
    // peripherals drive every control line that the device leaves free
    always_comb begin
        bus_i_o = (bus_o_i & bus_oe_i) | (ext_bus_i & ~bus_oe_i);
        // general pins released by both the device and the far side float to the pull-up level
        gp_i_o = (gp_o_i & gp_oe_i) | (ext_gp_i & ext_gp_en_i & ~gp_oe_i)
            | (~ext_gp_en_i & ~gp_oe_i);
    end
endmodule

// file: testbench/test_io_bus_and_gpio_pin_mux.sv
// self-checking bench for the control-bus and general-pin multiplexer
// assumes the far-side model on the pins and the register port of the design
`timescale 1ns/1ps
module test_io_bus_and_gpio_pin_mux;
    logic ref_clk_i, rst_i, wr, flow;
    logic [7:0] addr, wdata, rdata, go, goe, gi, ext_g, ext_g_en, d;
    logic [27:0] bo, boe, bi, ext_b, u;
    logic breq, stx, srx, crdy, ctrig, fe, ff, rack, tpar, cts1, irq0, irq1, rx2, cts2;
    logic [1:0] tmark;
    integer seed, fail_count, cmp_count, i, k;

    iobm_pin_mux i_dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .reg_wr_i(wr),
        .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_rdata_o(rdata),
        .control_bus_line_i(bi), .control_bus_line_o(bo), .control_bus_line_oe_o(boe),
        .gp_pin_i(gi), .gp_pin_o(go), .gp_pin_oe_o(goe),
        .mem_addr_i(u[15:0]), .mem_write_n_i(u[16]), .mem_read_n_i(u[17]),
        .memory_chip_select_n_i(u[21:18]), .mem_test_i(u[22]),
        .memory_transmit_ready_i(u[23]), .memory_receive_ready_i(u[24]),
        .mem_bus_request_n_o(breq), .memory_start_transmit_o(stx),
        .memory_start_receive_o(srx), .conv_addr_i(u[7:0]), .conv_cs_n_i(u[8]),
        .conv_read_convert_n_i(u[9]), .dac_write_n_i(u[10]), .dac_address_bit_i(u[13:11]),
        .conv_ready_o(crdy), .converter_trigger_in_o(ctrig), .tx_end_packet_ack_i(u[14]),
        .rx_parity_out_i(u[15]), .rx_end_packet_mark_i(u[17:16]),
        .fifo_read_strobe_n_i(u[18]), .queue_write_strobe_n_i(u[19]),
        .fifo_empty_n_o(fe), .fifo_full_n_o(ff), .tx_end_packet_mark_o(tmark),
        .rx_end_packet_ack_o(rack), .tx_parity_in_o(tpar), .first_serial_rts_n_i(u[25]),
        .first_serial_cts_n_o(cts1), .external_irq0_n_o(irq0), .external_irq1_n_o(irq1),
        .second_serial_tx_i(u[26]), .second_serial_rx_o(rx2),
        .second_serial_rts_n_i(u[27]), .second_serial_cts_n_o(cts2));

    iobm_far_side i_far (.bus_o_i(bo), .bus_oe_i(boe), .ext_bus_i(ext_b), .gp_o_i(go),
        .gp_oe_i(goe), .ext_gp_i(ext_g), .ext_gp_en_i(ext_g_en), .bus_i_o(bi), .gp_i_o(gi));

    initial begin
        ref_clk_i = 1'b0;
        forever #4 ref_clk_i = ~ref_clk_i;
    end

    task automatic step(input int n);
        repeat (n) @(posedge ref_clk_i);
        #1;
    endtask

    task automatic chk_pin(input logic [27:0] got, input logic [27:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // the gap cycle keeps the strobe from being raised twice in one step
    task automatic reg_wr(input logic [7:0] a, input logic [7:0] v);
        wr = 1'b1;
        addr = a;
        wdata = v;
        step(1);
        wr = 1'b0;
        step(1);
    endtask

    task automatic reg_rd(input logic [7:0] a, input logic [7:0] exp);
        addr = a;
        step(2);
        chk_reg(rdata, exp);
    endtask

    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    initial begin
        #(8 * 4000);
        fail_count++;
        print_verdict;
    end

    initial begin
        seed = 32'hab68;
        fail_count = 0;
        cmp_count = 0;
        rst_i = 1'b1;
        {wr, addr, wdata, u} = '0;
        // pins sit at their pull-up level while reset is held
        ext_b = 28'hFFFFFFF;
        ext_g = 8'hFF;
        ext_g_en = 8'hFF;
        step(3);
        chk_pin(bo, iobm_pkg::BUS_OUT_RESET);
        chk_pin(boe, iobm_pkg::BUS_OE_MEMORY);
        chk_pin(goe, 28'h0000000);
        rst_i = 1'b0;
        reg_rd(8'h01, 8'h00);
        reg_rd(8'h59, 8'h00);
        reg_rd(8'h72, 8'h00);
        $display("test reset done");
        for (i = 0; i < 20; i++) begin
            u = (i == 0) ? 28'h0000000 : (i == 1) ? 28'hFFFFFFF : 28'($random(seed));
            ext_b = (i == 0) ? 28'hFFFFFFF : 28'($random(seed));
            step(4);
            chk_pin(boe, iobm_pkg::BUS_OE_MEMORY);
            chk_pin(bo[24:0], u[24:0]);
            chk_pin({breq, stx, srx}, {ext_b[25], ext_b[26], ext_b[27]});
            chk_pin({tpar, rack, tmark, ctrig, crdy}, 28'h0000000);
        end
        $display("test memory role done");
        for (k = 0; k < 2; k++) begin
            flow = k[0];
            reg_wr(8'h01, {6'h00, flow, 1'b1});
            for (i = 0; i < 20; i++) begin
                u = 28'($random(seed));
                ext_b = 28'($random(seed));
                step(4);
                chk_pin(boe, {6'h00, flow ? iobm_pkg::FIFO_OE_TX : iobm_pkg::FIFO_OE_RX,
                    18'h3FFFF});
                chk_pin(bo[17:0], u[17:0]);
                chk_pin(flow ? bo[18] : bo[19], flow ? u[18] : u[19]);
                chk_pin({fe, ff}, flow ? {ext_b[20], 1'b1} : {1'b1, ext_b[21]});
                chk_pin({tpar, rack, tmark, ctrig, crdy}, ext_b[27:22]);
                chk_pin({breq, stx, srx}, 28'h0000004);
            end
        end
        $display("test converter and fifo roles done");
        reg_wr(8'h01, 8'h00);
        reg_wr(8'h64, 8'hFF);
        d = 8'($random(seed));
        reg_wr(8'h63, d);
        step(3);
        chk_pin(go, d);
        chk_pin(goe, 28'h00000FF);
        chk_pin({cts2, rx2, irq1, irq0, cts1}, 28'h000001F);
        reg_rd(8'h63, d);
        reg_rd(8'h64, 8'hFF);
        reg_wr(8'h20, 8'hFF);
        reg_rd(8'h20, 8'h00);
        reg_wr(8'h59, 8'h80);
        reg_wr(8'h01, 8'hC0);
        reg_wr(8'h72, 8'h80);
        for (i = 0; i < 10; i++) begin
            u = 28'($random(seed));
            ext_g = 8'($random(seed));
            step(4);
            chk_pin({go[6], go[4], go[0]}, u[27:25]);
            chk_pin(goe, 28'h0000051);
            chk_pin({cts2, rx2, irq1, irq0, cts1},
                {ext_g[7], ext_g[5], ext_g[3], ext_g[2], ext_g[1]});
        end
        reg_rd(8'h01, 8'hC0);
        reg_rd(8'h59, 8'h80);
        reg_rd(8'h72, 8'h80);
        $display("test general pins done");
        print_verdict;
    end
endmodule
